// File: src/pmic_supervisor_pkg.sv
/*
  Shared constants for the camera power supervisor: timing counts, the
  bit positions of the synchronised input vector and the sequencing table.
  Assumes a 25 MHz internal oscillator as the only clock.
*/
package pmic_supervisor_pkg;

  localparam int unsigned NUM_RAILS = 4;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TIMER_W = 17;

  // off time of a hiccup, continuous loss of regulation, one soft-start step
  localparam int unsigned HICCUP_NS = 3_200_000;
  localparam int unsigned REGLOSS_NS = 100_000;
  localparam int unsigned SS_STEP_NS = 500_000;
  localparam int unsigned HICCUP_CYCLES = HICCUP_NS / CLK_PERIOD_NS;
  localparam int unsigned REGLOSS_CYCLES = REGLOSS_NS / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP_CYCLES = SS_STEP_NS / CLK_PERIOD_NS;
  localparam logic [11:0] REGLOSS_LAST = 12'(REGLOSS_CYCLES - 1);

  // overcurrent: clamp seen on this many consecutive switching cycles
  localparam logic [1:0] OC_CLAMP_CYCLES = 2'h2;

  // spread spectrum: one step per 512 switching cycles, code 0..10, centre 5
  localparam logic [8:0] SPREAD_LAST = 9'h1FF;
  localparam logic [3:0] SPREAD_MAX = 4'hA;
  localparam logic [3:0] SPREAD_CENTRE = 4'h5;

  // order codes 0..5 are valid; per code, slot0..slot3 channel indices
  localparam logic [2:0] ORDER_LAST = 3'h5;
  localparam logic [47:0] ORDER_TABLE = {8'h6C, 8'h78, 8'hD8, 8'hE4, 8'hB4, 8'h9C};

  // bit positions inside the synchronised input vector
  localparam int unsigned P_OV = 0;
  localparam int unsigned P_UV = 4;
  localparam int unsigned P_LOSS = 8;
  localparam int unsigned P_WIN = 12;
  localparam int unsigned P_PEAK = 16;
  localparam int unsigned P_VALLEY = 20;
  localparam int unsigned P_CLAMP = 24;
  localparam int unsigned P_SUP = 28;
  localparam int unsigned P_ENHI = 29;
  localparam int unsigned P_ENLO = 30;
  localparam int unsigned P_ENFLT = 31;
  localparam int unsigned P_SOVP = 32;
  localparam int unsigned P_OT = 33;
  localparam int unsigned P_COOL = 34;
  localparam int unsigned P_TICK = 35;
  localparam int unsigned P_SST = 36;
  localparam int unsigned P_LATCH = 38;
  localparam int unsigned P_ORD = 39;
  localparam int unsigned P_VSEL = 42;
  localparam int unsigned P_PGSEL = 46;
  localparam int unsigned SYNC_W = 47;

  typedef enum logic [2:0] {ST_OFF, ST_SAMPLE, ST_RAMP, ST_ON, ST_HICCUP, ST_LATCHED} sup_state_t;

endpackage

// File: src/pmic_supervisor.sv
/*
  Supervisor logic of a four-rail camera power IC: enable qualification,
  sequenced soft-start, fault detection, hiccup or latch-off, discharge,
  rails-good output, spread-spectrum stepping and thermal shutdown.
  Assumes every analog indication and strap arrives asynchronously and is
  a clean comparator level; rail 0 is the first converter, 3 the linear rail.
*/
// Functional notes
// RULE1: enable only with supply above 3.8V and enable above 1.2V.
// RULE2: disable when supply drops or enable falls below 1.1V.
// RULE3: a floating enable pin counts as asserted.
// RULE4: soft-start length is 0.5, 1, 1.5 or 2 ms by trim.
// RULE5: trim chooses hiccup restart or permanent latch-off on faults.
// RULE6: 100 us continuous regulation loss stops switching; retry after 3.2 ms.
// RULE7: rail overvoltage shuts all rails for hiccup, then latched sequence restarts.
// RULE8: rail undervoltage shuts all rails for hiccup, then latched sequence restarts.
// RULE9: discharge paths active during a hiccup off period.
// RULE10: peak current turns high side off, low side on, until valley clears.
// RULE11: clamp on consecutive settled cycles flags overcurrent and enters hiccup.
// RULE12: rails good high only when on, all windows good, no fault.
// RULE13: rails good low on window loss, rail fault, overtemperature, supply overvoltage.
// RULE14: rails good high level selectable between 3.3V and 1.8V.
// RULE15: hiccup mode turns all channels off 3.2 ms, then resequences.
// RULE16: latch-off mode keeps channels off until supply or enable reset.
// RULE17: only protection faults trigger hiccup or latch; window loss only affects rails good.
// RULE18: a channel's discharge path is on whenever that channel is disabled.
// RULE19: soft-start ramps from zero and hands over to the fixed reference.
// RULE20: spread spectrum steps frequency within five percent every 512 switching cycles.
// RULE21: overtemperature at 170C disables all channels and enters hiccup or latch.
// RULE22: after thermal shutdown restart only when below 150C and hiccup done.
// RULE23: first converter always starts first, others follow the order select.
// RULE24: order and voltage selects sampled once at power-on and held.
// RULE25: out-of-range order select keeps channels two to four disabled.
// RULE26: power-off or hiccup or latch turns all channels off together.
// RULE27: durations counted on the oscillator; analog indications synchronised first.
// RULE28: next channel enabled only after current soft-start completes.
`timescale 1ns/100ps
module pmic_supervisor
  import pmic_supervisor_pkg::*;
#(
  parameter int unsigned HICCUP_CNT = HICCUP_CYCLES,
  parameter int unsigned SS_STEP_CNT = SS_STEP_CYCLES
) (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // supply, enable and temperature comparators
  input wire logic SUPPLY_ABOVE_UVLO_IN,
  input wire logic ENABLE_ABOVE_RISE_IN,
  input wire logic ENABLE_BELOW_FALL_IN,
  input wire logic ENABLE_FLOATING_IN,
  input wire logic SUPPLY_OVERVOLT_IN,
  input wire logic OVERTEMP_IN,
  input wire logic TEMP_COOLED_IN,
  // per-rail analog indications, bit 0 is the first converter
  input wire logic [3:0] RAIL_OVERVOLT_IN,
  input wire logic [3:0] RAIL_UNDERVOLT_IN,
  input wire logic [3:0] RAIL_REG_LOSS_IN,
  input wire logic [3:0] RAIL_IN_WINDOW_IN,
  input wire logic [3:0] PEAK_LIMIT_IN,
  input wire logic [3:0] VALLEY_LIMIT_IN,
  input wire logic [3:0] AMP_CLAMP_HIGH_IN,
  input wire logic SWITCH_CLOCK_IN,
  // trims and straps
  input wire logic [1:0] SOFTSTART_TRIM_IN,
  input wire logic LATCH_OFF_TRIM_IN,
  input wire logic [2:0] ORDER_SELECT_IN,
  input wire logic [3:0] VOLTAGE_SELECT_IN,
  input wire logic GOOD_LEVEL_SELECT_IN,
  // rail control
  output logic [3:0] RAIL_ENABLE_OUT,
  output logic [3:0] DISCHARGE_OUT,
  output logic [3:0] REF_HANDOVER_OUT,
  output logic [3:0] HIGH_SIDE_SWITCH_OUT,
  output logic [3:0] LOW_SIDE_SWITCH_OUT,
  output logic [3:0] VOLTAGE_CODE_OUT,
  output logic [3:0] SPREAD_SPECTRUM_OUT,
  // status
  output logic RAILS_GOOD_OUTPUT_OUT,
  output logic GOOD_LEVEL_3V3_OUT,
  output logic HICCUP_ACTIVE_OUT,
  output logic LATCHED_OFF_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; a change counts once stages two and three agree
  logic [SYNC_W-1:0] raw, s1, s2, s3, filt, next_filt;
  assign raw = {GOOD_LEVEL_SELECT_IN, VOLTAGE_SELECT_IN, ORDER_SELECT_IN, LATCH_OFF_TRIM_IN,
                SOFTSTART_TRIM_IN, SWITCH_CLOCK_IN, TEMP_COOLED_IN, OVERTEMP_IN, SUPPLY_OVERVOLT_IN,
                ENABLE_FLOATING_IN, ENABLE_BELOW_FALL_IN, ENABLE_ABOVE_RISE_IN, SUPPLY_ABOVE_UVLO_IN,
                AMP_CLAMP_HIGH_IN, VALLEY_LIMIT_IN, PEAK_LIMIT_IN, RAIL_IN_WINDOW_IN,
                RAIL_REG_LOSS_IN, RAIL_UNDERVOLT_IN, RAIL_OVERVOLT_IN};

  genvar b;
  generate
    for (b = 0; b < SYNC_W; b++) begin : g_sync
      // RULE27: synchronise analog
      assign next_filt[b] = (s2[b] == s3[b]) ? s3[b] : filt[b];
    end
  endgenerate

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  wire [3:0] ov = filt[P_OV +: 4];
  wire [3:0] uv = filt[P_UV +: 4];
  wire [3:0] loss = filt[P_LOSS +: 4];
  wire [3:0] win = filt[P_WIN +: 4];
  wire [3:0] peak = filt[P_PEAK +: 4];
  wire [3:0] valley = filt[P_VALLEY +: 4];
  wire [3:0] clamp = filt[P_CLAMP +: 4];
  wire sup_ok = filt[P_SUP];
  wire sup_ovp = filt[P_SOVP];
  wire hot = filt[P_OT];
  wire cool = filt[P_COOL];

  ////////////////////////////////////////////////////////////////////////////
  // enable qualification with hysteresis
  logic en_on, tick_prev;
  // RULE3: floating counts asserted
  wire next_en_on = (filt[P_ENHI] | filt[P_ENFLT]) ? 1'b1 : ((filt[P_ENLO]) ? 1'b0 : en_on);
  // RULE1: both thresholds met
  // RULE2: either one drops
  wire power_ok = sup_ok & en_on;
  wire tick = filt[P_TICK] & ~tick_prev;

  ////////////////////////////////////////////////////////////////////////////
  // latched selections and sequencing
  sup_state_t state, next_state;
  logic [1:0] slot, next_slot, sst_q;
  logic [2:0] order_q;
  logic latch_q, thermal_trip;
  logic [TIMER_W-1:0] ss_cnt, hic_cnt;
  logic [3:0] rail_en, handover, hs, loss_fault, oc;

  wire order_bad = order_q > ORDER_LAST;
  wire [7:0] order_map = ORDER_TABLE[{order_q, 3'h0} +: 8];
  wire [1:0] chan = order_bad ? 2'h0 : order_map[{slot, 1'b0} +: 2];
  wire [1:0] next_chan = order_bad ? 2'h0 : order_map[{next_slot, 1'b0} +: 2];
  // RULE4: trimmed soft-start length
  wire [TIMER_W-1:0] ss_last = TIMER_W'((32'(sst_q) + 32'h1) * SS_STEP_CNT - 32'h1);
  wire ss_done = (state == ST_RAMP) && (ss_cnt == ss_last);
  wire hic_done = hic_cnt == TIMER_W'(HICCUP_CNT - 1);
  wire running = (state == ST_RAMP) || (state == ST_ON);
  // RULE17: protection faults only
  wire prot_fault = running && ((|(rail_en & (ov | uv | oc | loss_fault))) || sup_ovp || hot);
  wire fault_state_hiccup = !latch_q;

  always_comb begin
    next_state = state;
    next_slot = slot;
    unique case (state)
      ST_OFF: begin
        if (power_ok) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        next_state = ST_RAMP;
        next_slot = 2'h0;
      end
      ST_RAMP, ST_ON: begin
        // RULE5: hiccup or latch
        // RULE21: overtemperature trips
        if (prot_fault) begin
          next_state = fault_state_hiccup ? ST_HICCUP : ST_LATCHED;
        end else if (ss_done) begin
          // RULE28: advance after soft-start
          // RULE25: bad order stops at channel one
          if (slot == 2'h3 || order_bad) begin
            next_state = ST_ON;
          end else begin
            next_slot = slot + 2'h1;
          end
        end
      end
      ST_HICCUP: begin
        // RULE22: wait for cool and timer
        // RULE7: restart from latched order
        // RULE8: undervoltage restarts too
        if (hic_done && (!thermal_trip || cool)) begin
          next_state = ST_RAMP;
          next_slot = 2'h0;
        end
      end
      ST_LATCHED: begin
        next_state = ST_LATCHED;
      end
    endcase
    // RULE16: only supply or enable loss (power_ok low) leaves latch
    if (!power_ok) begin
      next_state = ST_OFF;
    end
  end

  // RULE26: all off together
  // RULE23: first converter starts first
  wire next_running = (next_state == ST_RAMP) || (next_state == ST_ON);
  wire [3:0] chan_bit = 4'h1 << next_chan;
  wire [3:0] next_rail_en = !next_running ? 4'h0
                          : (rail_en | ((next_state == ST_RAMP) ? chan_bit : 4'h0));
  // RULE19: ramp then hand over
  wire [3:0] done_bit = ss_done ? (4'h1 << chan) : 4'h0;
  wire [3:0] next_handover = next_rail_en & (handover | done_bit);
  wire next_ss_restart = (next_state != ST_RAMP) || (next_slot != slot) || (state != ST_RAMP);

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= ST_OFF;
      slot <= 2'h0;
      en_on <= 1'b0;
      tick_prev <= 1'b0;
      ss_cnt <= '0;
      hic_cnt <= '0;
      rail_en <= 4'h0;
      handover <= 4'h0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      en_on <= next_en_on;
      tick_prev <= filt[P_TICK];
      ss_cnt <= next_ss_restart ? '0 : ss_cnt + 1'b1;
      // RULE15: 3.2 ms off time
      hic_cnt <= (state != ST_HICCUP) ? '0 : (hic_done ? hic_cnt : hic_cnt + 1'b1);
      rail_en <= next_rail_en;
      handover <= next_handover;
    end
  end

  // RULE24: sample selects once
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      order_q <= 3'h0;
      sst_q <= 2'h0;
      latch_q <= 1'b0;
      VOLTAGE_CODE_OUT <= 4'h0;
    end else if (state == ST_SAMPLE) begin
      order_q <= filt[P_ORD +: 3];
      sst_q <= filt[P_SST +: 2];
      latch_q <= filt[P_LATCH];
      VOLTAGE_CODE_OUT <= filt[P_VSEL +: 4];
    end
  end

  // set wins, but prot_fault needs running: hot in the cycle the hiccup ends does not set it
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      thermal_trip <= 1'b0;
    end else if (prot_fault && hot) begin
      thermal_trip <= 1'b1;
    end else if (next_running || state == ST_OFF) begin
      thermal_trip <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-rail protection and switch control
  genvar r;
  generate
    for (r = 0; r < NUM_RAILS; r++) begin : g_rail
      logic [11:0] loss_cnt;
      logic [1:0] clamp_cnt;
      // RULE6: 100 us continuous loss
      assign loss_fault[r] = loss[r] && (loss_cnt == REGLOSS_LAST);
      // RULE11: consecutive settled clamps
      assign oc[r] = clamp_cnt >= OC_CLAMP_CYCLES;
      // RULE10: peak off, wait valley
      wire next_hs = next_rail_en[r] & ~peak[r] & (hs[r] | ~valley[r]);
      always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          loss_cnt <= 12'h0;
          clamp_cnt <= 2'h0;
          hs[r] <= 1'b0;
          LOW_SIDE_SWITCH_OUT[r] <= 1'b0;
        end else begin
          loss_cnt <= (rail_en[r] && handover[r] && loss[r] && !loss_fault[r]) ? loss_cnt + 12'h1
                    : (loss[r] && loss_fault[r]) ? loss_cnt : 12'h0;
          if (!handover[r]) begin
            clamp_cnt <= 2'h0;
          end else if (tick) begin
            clamp_cnt <= !clamp[r] ? 2'h0 : (oc[r] ? clamp_cnt : clamp_cnt + 2'h1);
          end
          hs[r] <= next_hs;
          LOW_SIDE_SWITCH_OUT[r] <= next_rail_en[r] & ~next_hs;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // spread spectrum, rails good and status outputs
  logic [8:0] spread_cnt;
  logic spread_up;
  wire spread_step = tick && (spread_cnt == SPREAD_LAST);

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      spread_cnt <= 9'h0;
      spread_up <= 1'b1;
      SPREAD_SPECTRUM_OUT <= SPREAD_CENTRE;
    end else if (!running) begin
      spread_cnt <= 9'h0;
      spread_up <= 1'b1;
      SPREAD_SPECTRUM_OUT <= SPREAD_CENTRE;
    end else begin
      // RULE20: step every 512 cycles
      spread_cnt <= tick ? spread_cnt + 9'h1 : spread_cnt;
      if (spread_step) begin
        SPREAD_SPECTRUM_OUT <= spread_up ? SPREAD_SPECTRUM_OUT + 4'h1 : SPREAD_SPECTRUM_OUT - 4'h1;
        spread_up <= spread_up ? (SPREAD_SPECTRUM_OUT + 4'h1 < SPREAD_MAX) : (SPREAD_SPECTRUM_OUT == 4'h1);
      end
    end
  end

  // RULE12: on, windows good, no fault
  // RULE13: any fault drops it
  wire next_good = (next_state == ST_ON) && (state == ST_ON) && (&win) && !prot_fault;

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RAILS_GOOD_OUTPUT_OUT <= 1'b0;
      GOOD_LEVEL_3V3_OUT <= 1'b0;
      DISCHARGE_OUT <= 4'hF;
      HICCUP_ACTIVE_OUT <= 1'b0;
      LATCHED_OFF_OUT <= 1'b0;
    end else begin
      RAILS_GOOD_OUTPUT_OUT <= next_good;
      // RULE14: good level select
      GOOD_LEVEL_3V3_OUT <= filt[P_PGSEL];
      // RULE18: discharge when disabled
      // RULE9: covers hiccup off time
      DISCHARGE_OUT <= ~next_rail_en;
      HICCUP_ACTIVE_OUT <= next_state == ST_HICCUP;
      LATCHED_OFF_OUT <= next_state == ST_LATCHED;
    end
  end

  assign RAIL_ENABLE_OUT = rail_en;
  assign REF_HANDOVER_OUT = handover;
  assign HIGH_SIDE_SWITCH_OUT = hs;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  property p_off_together;
    !power_ok || prot_fault |=> RAIL_ENABLE_OUT == 4'h0;
  endproperty
  a_off_together: assert property (p_off_together) else $error("rails not all off"); // RULE26

  property p_first_rail;
    RAIL_ENABLE_OUT != 4'h0 |-> RAIL_ENABLE_OUT[0];
  endproperty
  a_first_rail: assert property (p_first_rail) else $error("first converter not on"); // RULE23

  property p_discharge;
    ##1 DISCHARGE_OUT == ~RAIL_ENABLE_OUT;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge mismatch"); // RULE18

  property p_hiccup_len;
    (state == ST_HICCUP) && !hic_done && power_ok |=> state == ST_HICCUP;
  endproperty
  a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup ended early"); // RULE15

  property p_latch_holds;
    (state == ST_LATCHED) && power_ok |=> LATCHED_OFF_OUT && RAIL_ENABLE_OUT == 4'h0;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latch left without reset"); // RULE16

  property p_good_cause;
    RAILS_GOOD_OUTPUT_OUT |-> $past(state == ST_ON && (&win) && !prot_fault);
  endproperty
  a_good_cause: assert property (p_good_cause) else $error("rails good without cause"); // RULE12

  property p_good_drop;
    (state == ST_ON) && !(&win) && power_ok && !prot_fault |=> !RAILS_GOOD_OUTPUT_OUT && state == ST_ON;
  endproperty
  a_good_drop: assert property (p_good_drop) else $error("rails good stuck or window faulted"); // RULE13

  property p_seq_wait;
    (state == ST_RAMP) && !ss_done && power_ok && !prot_fault |=> $stable(RAIL_ENABLE_OUT);
  endproperty
  a_seq_wait: assert property (p_seq_wait) else $error("next rail before soft-start end"); // RULE28

  property p_peak_off;
    (peak & hs) != 4'h0 |=> (HIGH_SIDE_SWITCH_OUT & $past(peak)) == 4'h0;
  endproperty
  a_peak_off: assert property (p_peak_off) else $error("high side on during peak"); // RULE10

  property p_bad_order;
    order_bad && running |-> RAIL_ENABLE_OUT[3:1] == 3'h0;
  endproperty
  a_bad_order: assert property (p_bad_order) else $error("rails on with bad order"); // RULE25

  property p_hot_wait;
    (state == ST_HICCUP) && thermal_trip && !cool |=> state != ST_RAMP;
  endproperty
  a_hot_wait: assert property (p_hot_wait) else $error("restart while hot"); // RULE22

  c_reach_on: cover property (state == ST_RAMP ##[1:1000] state == ST_ON);
  c_hiccup: cover property (state == ST_ON ##1 state == ST_HICCUP);
  c_latched: cover property (state == ST_ON ##1 state == ST_LATCHED);
  c_spread: cover property (spread_step);

endmodule

// File: tb/sys_side_model.sv
/*
  System-side partner: drives supply and enable comparators, a free-running
  switching clock and ideal rails that sit in window once enabled.
  Assumes the bench oscillator clock; commands come from the testbench.
*/
`timescale 1ns/100ps
module sys_side_model (
  // commands from the bench
  input wire logic clk,
  input wire logic supply_cmd,
  input wire logic enable_cmd,
  input wire logic [3:0] rail_en,
  // toward the supervisor
  output logic supply_ok,
  output logic en_rise,
  output logic en_fall,
  output logic sw_clk,
  output logic [3:0] in_window
);
  logic sw_div;
  initial begin
    {supply_ok, en_rise, en_fall, sw_clk, sw_div, in_window} = '0;
  end
  // comparator levels follow the supply and enable pins
  always @(posedge clk) begin
    supply_ok <= supply_cmd;
    en_rise <= enable_cmd;
    en_fall <= !enable_cmd;
    in_window <= rail_en;
    // two clocks per level, else the agreeing filter stages never see it settle
    sw_div <= !sw_div;
    if (sw_div) sw_clk <= !sw_clk;
  end
endmodule

// File: tb/camera_pmic_fault_supervisor_tb.sv
/*
  Self-checking bench for the supervisor: sequencing, faults, hiccup,
  latch-off, rails good and spread spectrum.
  Assumes the design package and the system-side partner model.
*/
`timescale 1ns/100ps
module camera_pmic_fault_supervisor_tb;
  import pmic_supervisor_pkg::*;
  // short counts keep the run brief
  localparam int HC = 40;
  localparam int SS = 20;
  localparam logic [15:0] ORD [6] = '{16'h0312, 16'h0132, 16'h0123, 16'h0213, 16'h0231, 16'h0321};
  logic clk, rst_b, sup_cmd, en_cmd, sup_ok, en_rise, en_fall, en_float, sovp, ot, cooled, sw_clk, latch, lvl;
  logic [3:0] ov, uv, loss, win, win_kill, peak, valley, clamp, vsel, en, dis, ho, hs, ls, vcode, spread, s4;
  logic [2:0] osel;
  logic [1:0] trim;
  logic good, lvl3, hic, lat;
  logic [31:0] obs;
  int bad_count, num_checks, waited;
  assign obs = {6'h00, lat, hic, good, lvl3, ls[0], hs[0], vcode, ho, spread, dis, en};

  sys_side_model model (.clk(clk), .supply_cmd(sup_cmd), .enable_cmd(en_cmd), .rail_en(en),
    .supply_ok(sup_ok), .en_rise(en_rise), .en_fall(en_fall), .sw_clk(sw_clk), .in_window(win));

  pmic_supervisor #(.HICCUP_CNT(HC), .SS_STEP_CNT(SS)) dut (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .SUPPLY_ABOVE_UVLO_IN(sup_ok), .ENABLE_ABOVE_RISE_IN(en_rise),
    .ENABLE_BELOW_FALL_IN(en_fall), .ENABLE_FLOATING_IN(en_float), .SUPPLY_OVERVOLT_IN(sovp),
    .OVERTEMP_IN(ot), .TEMP_COOLED_IN(cooled), .RAIL_OVERVOLT_IN(ov), .RAIL_UNDERVOLT_IN(uv),
    .RAIL_REG_LOSS_IN(loss), .RAIL_IN_WINDOW_IN(win & ~win_kill), .PEAK_LIMIT_IN(peak),
    .VALLEY_LIMIT_IN(valley), .AMP_CLAMP_HIGH_IN(clamp), .SWITCH_CLOCK_IN(sw_clk),
    .SOFTSTART_TRIM_IN(trim), .LATCH_OFF_TRIM_IN(latch), .ORDER_SELECT_IN(osel),
    .VOLTAGE_SELECT_IN(vsel), .GOOD_LEVEL_SELECT_IN(lvl), .RAIL_ENABLE_OUT(en), .DISCHARGE_OUT(dis),
    .REF_HANDOVER_OUT(ho), .HIGH_SIDE_SWITCH_OUT(hs), .LOW_SIDE_SWITCH_OUT(ls),
    .VOLTAGE_CODE_OUT(vcode), .SPREAD_SPECTRUM_OUT(spread), .RAILS_GOOD_OUTPUT_OUT(good),
    .GOOD_LEVEL_3V3_OUT(lvl3), .HICCUP_ACTIVE_OUT(hic), .LATCHED_OFF_OUT(lat));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait on a masked view of the outputs, counts cycles in waited
  task automatic wait_obs(input string nm, input logic [31:0] m, input logic [31:0] v, input int lim);
    waited = 0;
    #1;
    while ((obs & m) !== v && waited < lim) begin
      @(posedge clk);
      #1;
      waited++;
    end
    check(nm, obs & m, v);
    // hand back on a rising edge so the caller drives on it
    @(posedge clk);
  endtask

  task automatic power_up(input int code, input logic [1:0] t);
    logic [3:0] m;
    logic [3:0] p;
    m = 4'h1;
    @(posedge clk);
    osel <= 3'(code);
    trim <= t;
    vsel <= 4'(code + 1);
    sup_cmd <= 1'b1;
    en_cmd <= 1'b1;
    wait_obs("first rail", 32'hF, 32'h1, 20);
    // straps move after sampling; the latched copy must not
    osel <= 3'h7;
    vsel <= 4'h0;
    if (code > 5) begin
      repeat (200) @(posedge clk);
      #1;
      check("bad order", obs & 32'h80000F, 32'h1);
    end else begin
      for (int s = 1; s < 4; s++) begin
        p = m;
        m[ORD[code][12 - 4 * s +: 2]] = 1'b1;
        wait_obs("rail order", 32'hF, {28'h0, m}, 200);
        check("handover", {28'h0, ho & p}, {28'h0, p});
        if (s == 1) check("ramp", 32'(waited >= (t + 1) * SS - 2 && waited <= (t + 1) * SS + 1), 32'h1);
      end
      wait_obs("good", 32'h008F00F0, 32'h00800000 | 32'((code + 1) << 16), 100);
    end
  endtask

  task automatic power_dn();
    @(posedge clk);
    sup_cmd <= 1'b0;
    en_cmd <= 1'b0;
    wait_obs("power off", 32'h008000FF, 32'hF0, 12);
  endtask

  task automatic fault(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: ov[1] <= v;
      1: uv[3] <= v;
      2: sovp <= v;
      3: clamp[0] <= v;
      4: loss[2] <= v;
      default: begin
        ot <= v;
        cooled <= cooled && !v;
      end
    endcase
  endtask

  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  initial begin
    #(40 * 30000);
    bad_count++;
    final_report();
  end

  initial begin
    {rst_b, sup_cmd, en_cmd, en_float, sovp, ot, latch, lvl} = '0;
    {ov, uv, loss, win_kill, peak, valley, clamp, vsel, osel, trim} = '0;
    cooled = 1'b1;
    bad_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("reset", obs & 32'hFFF, 32'h5F0);
    for (int c = 0; c < 7; c++) begin
      power_up(c, 2'(c));
      power_dn();
    end
    en_float <= 1'b1;
    sup_cmd <= 1'b1;
    wait_obs("float", 32'hF, 32'h1, 20);
    power_dn();
    en_float <= 1'b0;
    power_up(2, 2'h0);
    // ov, uv, supply ov, clamp, regulation loss, overtemperature
    for (int k = 0; k < 6; k++) begin
      fault(k, 1'b1);
      wait_obs("fault", 32'h018000FF, 32'h010000F0, 2700);
      fault(k, 1'b0);
      if (k == 5) begin
        repeat (80) @(posedge clk);
        cooled <= 1'b1;
        #1;
        check("hot hold", {28'h0, en}, 32'h0);
      end
      wait_obs("restart", 32'h0100000F, 32'h1, 100);
      if (k < 5) check("hiccup", 32'(waited >= HC - 3 && waited <= HC + 2), 32'h1);
      wait_obs("reseq", 32'h0080000F, 32'h0080000F, 200);
    end
    win_kill <= 4'h4;
    wait_obs("window", 32'h0080000F, 32'hF, 10);
    repeat (60) @(posedge clk);
    win_kill <= 4'h0;
    peak[0] <= 1'b1;
    valley[0] <= 1'b1;
    #1;
    check("no hiccup", obs & 32'h0180000F, 32'hF);
    wait_obs("peak", 32'h300000, 32'h200000, 10);
    peak[0] <= 1'b0;
    repeat (10) @(posedge clk);
    valley[0] <= 1'b0;
    #1;
    check("valley hold", obs & 32'h300000, 32'h200000);
    wait_obs("valley", 32'h300000, 32'h100000, 10);
    #1 s4 = spread;
    for (int i = 0; i < 2600 && spread === s4; i++) begin
      @(posedge clk);
      #1;
    end
    check("spread", 32'(spread == s4 + 4'h1 || spread == s4 - 4'h1), 32'h1);
    @(posedge clk);
    lvl <= 1'b1;
    wait_obs("lvl 3v3", 32'h400000, 32'h400000, 8);
    lvl <= 1'b0;
    wait_obs("lvl 1v8", 32'h400000, 32'h0, 8);
    power_dn();
    latch <= 1'b1;
    power_up(2, 2'h0);
    fault(5, 1'b1);
    wait_obs("latch", 32'h020000FF, 32'h020000F0, 20);
    fault(5, 1'b0);
    repeat (100) @(posedge clk);
    #1;
    check("stay off", obs & 32'h020000FF, 32'h020000F0);
    power_dn();
    latch <= 1'b0;
    power_up(1, 2'h0);
    final_report();
  end
endmodule
